/* inc/port_regs_pkg.sv */
`default_nettype none
package port_regs_pkg;
	localparam int PORTS = 4;
	localparam int CELL_PORTS = 3;
	localparam int FUNC_PORTS = 2;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 6;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int PORT_D = 3;

	// address = {port index, register index}
	localparam int PORT_SEL_LSB = 4;
	localparam logic [3:0] REG_INPUT_LEVEL = 4'h0;
	localparam logic [3:0] REG_FUNCTION_SELECT = 4'h1;
	localparam logic [3:0] REG_OUTPUT_VALUE = 4'h2;
	localparam logic [3:0] REG_DIRECTION = 4'h3;
	localparam logic [3:0] REG_DRIVE_SELECT = 4'h4;
	localparam logic [3:0] REG_OUTPUT_CELL = 4'h5;
	localparam logic [3:0] REG_OUTPUT_CELL_MASK = 4'h6;
	localparam logic [3:0] REG_INPUT_CELL = 4'h7;
	localparam logic [3:0] REG_DRIVER_ENABLE = 4'h8;

	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// per-port bit masks, index [port], port A in the low byte
	localparam logic [PORTS-1:0][7:0] PIN_MASK = {8'h07, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [PORTS-1:0][7:0] OPEN_DRAIN_MASK = {8'h00, 8'hFF, 8'hF0, 8'hF0};
	localparam logic [PORTS-1:0][7:0] SLEW_MASK = {8'h07, 8'h00, 8'h0F, 8'h0F};
endpackage
`default_nettype wire

/* inc/port_ctrl_if.sv */
`default_nettype none
interface port_ctrl_if #(parameter int W = 8);
	logic [W-1:0] dir;
	logic [W-1:0] value;
	logic [W-1:0] open_drain;
	logic [W-1:0] fast_slew;
	logic [W-1:0] pin_out;
	logic [W-1:0] pin_oe_n;
	logic [W-1:0] slew_fast;
	logic [W-1:0] eff_oe;
	modport cfg (output dir, value, open_drain, fast_slew,
		input pin_out, pin_oe_n, slew_fast, eff_oe);
	modport pad (input dir, value, open_drain, fast_slew,
		output pin_out, pin_oe_n, slew_fast, eff_oe);
endinterface
`default_nettype wire

/* rtl/output_cell_group.sv */
`default_nettype none
module output_cell_group #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] pld_d_i,
	input wire logic pld_load_i,
	input wire logic [W-1:0] host_d_i,
	input wire logic host_load_i,
	input wire logic [W-1:0] mask_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;
	logic [W-1:0] host_take;

	// a masked bit keeps following the logic array, only the host load is blocked
	assign host_take = host_load_i ? ~mask_i : '0;
	assign q_next = (host_take & host_d_i) | (~host_take & (pld_load_i ? pld_d_i : q_reg));

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			q_reg <= '0;
		else
			q_reg <= q_next;
	end

	assign q_o = q_reg;
endmodule
`default_nettype wire

/* rtl/pin_driver.sv */
`default_nettype none
module pin_driver (
	input wire logic clk_i,
	input wire logic rstn_i,
	port_ctrl_if.pad ctl
);
	logic [7:0] out_reg;
	logic [7:0] oe_n_reg;
	logic [7:0] slew_reg;
	logic [7:0] eff_reg;
	logic [7:0] drive_low_only;
	logic [7:0] oe_n_next;

	// open drain only pulls low; a one releases the pin to the pull-up
	assign drive_low_only = ctl.open_drain & ctl.value;
	assign oe_n_next = ~(ctl.dir & ~drive_low_only);

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			out_reg <= 8'h00;
			oe_n_reg <= 8'hFF;
			slew_reg <= 8'h00;
			eff_reg <= 8'h00;
		end
		else
		begin
			out_reg <= ctl.value & ~ctl.open_drain;
			oe_n_reg <= oe_n_next;
			slew_reg <= ctl.fast_slew;
			eff_reg <= ~oe_n_next;
		end
	end

	assign ctl.pin_out = out_reg;
	assign ctl.pin_oe_n = oe_n_reg;
	assign ctl.slew_fast = slew_reg;
	assign ctl.eff_oe = eff_reg;
endmodule
`default_nettype wire

/* rtl/port_config_data_regs.sv */
`default_nettype none
module port_config_data_regs #(
	parameter int W = port_regs_pkg::PORT_W
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [port_regs_pkg::ADDR_W-1:0] host_addr_i,
	input wire logic [W-1:0] host_wdata_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	output logic [W-1:0] host_rdata_o,
	input wire logic [port_regs_pkg::PORTS-1:0][W-1:0] pin_i,
	output logic [port_regs_pkg::PORTS-1:0][W-1:0] pin_o,
	output logic [port_regs_pkg::PORTS-1:0][W-1:0] pin_oe_n_o,
	output logic [port_regs_pkg::PORTS-1:0][W-1:0] slew_fast_o,
	input wire logic [port_regs_pkg::CELL_PORTS-1:0][W-1:0] logic_oe_i,
	input wire logic [port_regs_pkg::CELL_PORTS-1:0][W-1:0] pin_uses_cell_i,
	input wire logic [port_regs_pkg::FUNC_PORTS-1:0][W-1:0] latched_addr_i,
	input wire logic group_first_to_second_i,
	input wire logic group_second_to_third_i,
	input wire logic [W-1:0] group_first_d_i,
	input wire logic group_first_load_i,
	input wire logic [W-1:0] group_second_d_i,
	input wire logic group_second_load_i,
	output logic [W-1:0] output_cell_group_first_o,
	output logic [W-1:0] output_cell_group_second_o,
	input wire logic [port_regs_pkg::CELL_PORTS-1:0] input_cell_strobe_i,
	output logic [port_regs_pkg::CELL_PORTS-1:0][W-1:0] input_cell_o,
	input wire logic data_port_mode_i,
	input wire logic peripheral_mode_i,
	input wire logic bus_drive_i,
	input wire logic [W-1:0] bus_data_i
);
	localparam int NP = port_regs_pkg::PORTS;
	localparam int NC = port_regs_pkg::CELL_PORTS;
	localparam int NF = port_regs_pkg::FUNC_PORTS;

	logic [NP-1:0][W-1:0] function_reg;
	logic [NP-1:0][W-1:0] direction_reg;
	logic [NP-1:0][W-1:0] drive_reg;
	logic [NP-1:0][W-1:0] out_value_reg;
	logic [NC-1:0][W-1:0] cell_mask_reg;
	logic [NC-1:0][W-1:0] input_cell_reg;
	logic [W-1:0] rdata_reg;
	logic [W-1:0] rdata_next;

	logic [NP-1:0][W-1:0] pin_mask;
	logic [NP-1:0][W-1:0] eff_oe;
	logic [NP-1:0][W-1:0] cell_view;
	logic [NP-1:0][W-1:0] pad_out;
	logic [NP-1:0][W-1:0] pad_oe_n;
	logic [NP-1:0][W-1:0] pad_slew;

	// address is {port, register}; writes decode once, port_hit picks the slice
	wire logic [3:0] reg_sel = host_addr_i[port_regs_pkg::PORT_SEL_LSB-1:0];
	wire logic [1:0] port_sel = host_addr_i[port_regs_pkg::ADDR_W-1:port_regs_pkg::PORT_SEL_LSB];
	wire logic [NP-1:0] port_hit = 4'h1 << port_sel;
	wire logic wr_func = host_wr_i && reg_sel == port_regs_pkg::REG_FUNCTION_SELECT;
	wire logic wr_dir = host_wr_i && reg_sel == port_regs_pkg::REG_DIRECTION;
	wire logic wr_drive = host_wr_i && reg_sel == port_regs_pkg::REG_DRIVE_SELECT;
	wire logic wr_out = host_wr_i && reg_sel == port_regs_pkg::REG_OUTPUT_VALUE;
	wire logic wr_cell = host_wr_i && reg_sel == port_regs_pkg::REG_OUTPUT_CELL;
	wire logic wr_mask = host_wr_i && reg_sel == port_regs_pkg::REG_OUTPUT_CELL_MASK;

	// host port A is where the bus data lines sit; general I/O is off there in bus modes
	wire logic port_a_bus = data_port_mode_i || peripheral_mode_i;

	// group routing: first group to A or B, second group to B or C
	wire logic first_on_a = !group_first_to_second_i;
	wire logic first_on_b = group_first_to_second_i;
	wire logic second_on_b = !group_second_to_third_i;
	wire logic second_on_c = group_second_to_third_i;

	// port B prefers the first group when both are routed onto it
	wire logic first_host_load = wr_cell && ((port_hit[port_regs_pkg::PORT_A] && first_on_a)
		|| (port_hit[port_regs_pkg::PORT_B] && first_on_b));
	wire logic second_host_load = wr_cell && ((port_hit[port_regs_pkg::PORT_B] && second_on_b
		&& !first_on_b) || (port_hit[port_regs_pkg::PORT_C] && second_on_c));
	wire logic [W-1:0] first_mask = first_on_a ? cell_mask_reg[port_regs_pkg::PORT_A]
		: cell_mask_reg[port_regs_pkg::PORT_B];
	wire logic [W-1:0] second_mask = second_on_c ? cell_mask_reg[port_regs_pkg::PORT_C]
		: cell_mask_reg[port_regs_pkg::PORT_B];

	// cells live with their group; routing decides which port sees them, which port's writes load them and whose mask applies
	output_cell_group #(
		.W(W)
	) first_group (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pld_d_i(group_first_d_i),
		.pld_load_i(group_first_load_i),
		.host_d_i(host_wdata_i),
		.host_load_i(first_host_load),
		.mask_i(first_mask),
		.q_o(output_cell_group_first_o)
	);

	output_cell_group #(
		.W(W)
	) second_group (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pld_d_i(group_second_d_i),
		.pld_load_i(group_second_load_i),
		.host_d_i(host_wdata_i),
		.host_load_i(second_host_load),
		.mask_i(second_mask),
		.q_o(output_cell_group_second_o)
	);

	// ports A and C read zero at their cell location with no group routed; port B with no group routed shows the second group
	assign cell_view[port_regs_pkg::PORT_A] = first_on_a ? output_cell_group_first_o : 8'h00;
	assign cell_view[port_regs_pkg::PORT_B] = first_on_b ? output_cell_group_first_o
		: output_cell_group_second_o;
	assign cell_view[port_regs_pkg::PORT_C] = second_on_c ? output_cell_group_second_o : 8'h00;
	assign cell_view[port_regs_pkg::PORT_D] = 8'h00;

	// one slice per port: config flops, value select, pad flops
	genvar p;
	generate
		for (p = 0; p < NP; p++)
		begin : g_port
			port_ctrl_if #(.W(W)) ctl ();
			logic [W-1:0] io_value;
			logic [W-1:0] oe_term;
			logic [W-1:0] addr_bits;
			logic [W-1:0] cell_bits;

			assign pin_mask[p] = port_regs_pkg::PIN_MASK[p];

			// unused bit positions hold zero and ignore writes
			always_ff @(posedge clk_i)
			begin
				if (!rstn_i)
				begin
					direction_reg[p] <= port_regs_pkg::CFG_RESET;
					drive_reg[p] <= port_regs_pkg::CFG_RESET;
					out_value_reg[p] <= port_regs_pkg::CFG_RESET;
				end
				else
				begin
					if (wr_dir && port_hit[p])
						direction_reg[p] <= host_wdata_i & pin_mask[p];
					if (wr_drive && port_hit[p])
						drive_reg[p] <= host_wdata_i & (port_regs_pkg::OPEN_DRAIN_MASK[p]
							| port_regs_pkg::SLEW_MASK[p]);
					if (wr_out && port_hit[p])
						out_value_reg[p] <= host_wdata_i & pin_mask[p];
				end
			end

			// address-out exists on the first two ports only
			if (p < NF)
			begin : g_func
				always_ff @(posedge clk_i)
				begin
					if (!rstn_i)
						function_reg[p] <= port_regs_pkg::CFG_RESET;
					else if (wr_func && port_hit[p])
						function_reg[p] <= host_wdata_i;
				end
				assign addr_bits = latched_addr_i[p];
			end
			else
			begin : g_no_func
				assign function_reg[p] = 8'h00;
				assign addr_bits = 8'h00;
			end

			// port D: no logic enable term and no input cells, direction alone decides
			if (p < NC)
			begin : g_cell
				always_ff @(posedge clk_i)
				begin
					if (!rstn_i)
					begin
						cell_mask_reg[p] <= port_regs_pkg::MASK_RESET;
						input_cell_reg[p] <= 8'h00;
					end
					else
					begin
						if (wr_mask && port_hit[p])
							cell_mask_reg[p] <= host_wdata_i;
						if (input_cell_strobe_i[p])
							input_cell_reg[p] <= pin_i[p];
					end
				end
				assign input_cell_o[p] = input_cell_reg[p];
				assign cell_bits = pin_uses_cell_i[p];
				assign oe_term = direction_reg[p] | logic_oe_i[p];
			end
			else
			begin : g_no_cell
				assign cell_bits = 8'h00;
				assign oe_term = direction_reg[p];
			end

			// bitwise selection keeps every control on its own pin position
			assign io_value = (function_reg[p] & addr_bits)
				| (~function_reg[p] & cell_bits & cell_view[p])
				| (~function_reg[p] & ~cell_bits & out_value_reg[p]);

			// bus modes take over port A direction, value and open drain (slew stays with drive_reg), so registers cannot fight the host bus
			if (p == port_regs_pkg::PORT_A)
			begin : g_bus
				assign ctl.dir = port_a_bus ? {W{bus_drive_i}} : oe_term;
				assign ctl.value = port_a_bus ? bus_data_i : io_value;
				assign ctl.open_drain = port_a_bus ? 8'h00
					: drive_reg[p] & port_regs_pkg::OPEN_DRAIN_MASK[p];
			end
			else
			begin : g_plain
				assign ctl.dir = oe_term & pin_mask[p];
				assign ctl.value = io_value & pin_mask[p];
				assign ctl.open_drain = drive_reg[p] & port_regs_pkg::OPEN_DRAIN_MASK[p];
			end
			assign ctl.fast_slew = drive_reg[p] & port_regs_pkg::SLEW_MASK[p];

			// pad flops cost a cycle of latency but keep the pins glitch-free
			pin_driver drv (
				.clk_i(clk_i),
				.rstn_i(rstn_i),
				.ctl(ctl)
			);

			assign pad_out[p] = ctl.pin_out;
			assign pad_oe_n[p] = ctl.pin_oe_n;
			assign pad_slew[p] = ctl.slew_fast;
			assign eff_oe[p] = ctl.eff_oe;
		end
	endgenerate

	// pad copies go straight out, no logic between flop and pin
	assign pin_o = pad_out;
	assign pin_oe_n_o = pad_oe_n;
	assign slew_fast_o = pad_slew;

	// read data; registers missing on a port answer zero
	wire logic cell_port = port_sel < 2'(NC);
	wire logic func_port = port_sel < 2'(NF);

	// start from zero so absent registers and ports need no arm of their own
	always_comb
	begin
		rdata_next = port_regs_pkg::READ_UNMAPPED;
		unique case (reg_sel)
			port_regs_pkg::REG_INPUT_LEVEL:
				rdata_next = pin_i[port_sel] & pin_mask[port_sel];
			port_regs_pkg::REG_FUNCTION_SELECT:
				rdata_next = func_port ? function_reg[port_sel] : 8'h00;
			port_regs_pkg::REG_OUTPUT_VALUE:
				rdata_next = out_value_reg[port_sel];
			port_regs_pkg::REG_DIRECTION:
				rdata_next = direction_reg[port_sel];
			port_regs_pkg::REG_DRIVE_SELECT:
				rdata_next = drive_reg[port_sel];
			port_regs_pkg::REG_OUTPUT_CELL:
				rdata_next = cell_view[port_sel];
			port_regs_pkg::REG_OUTPUT_CELL_MASK:
				rdata_next = cell_port ? cell_mask_reg[port_sel[1:0]] : 8'h00;
			port_regs_pkg::REG_INPUT_CELL:
				rdata_next = cell_port ? input_cell_reg[port_sel[1:0]] : 8'h00;
			port_regs_pkg::REG_DRIVER_ENABLE:
				rdata_next = cell_port ? eff_oe[port_sel] : 8'h00;
			default:
				rdata_next = port_regs_pkg::READ_UNMAPPED;
		endcase
	end

	// captured only on a read strobe, so the value holds between reads
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			rdata_reg <= 8'h00;
		else if (host_rd_i)
			rdata_reg <= rdata_next;
	end

	assign host_rdata_o = rdata_reg;
endmodule
`default_nettype wire

/* sim/port_regs_sva.sv */
`default_nettype none
module port_regs_sva #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [5:0] host_addr_i,
	input wire logic [W-1:0] host_wdata_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [W-1:0] host_rdata_o,
	input wire logic [3:0][W-1:0] pin_oe_n_o,
	input wire logic [3:0][W-1:0] slew_fast_o,
	input wire logic [2:0][W-1:0] logic_oe_i
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence dir_d_write;
		host_wr_i && host_addr_i == 6'h33;
	endsequence
	sequence out_a_write;
		host_wr_i && host_addr_i == 6'h02;
	endsequence
	sequence out_a_read;
		host_rd_i && host_addr_i == 6'h02;
	endsequence

	AST_RESET_OE: assert property ($rose(rstn_i) |-> pin_oe_n_o == '1)
		else $error("drivers not off after reset");
	AST_DIR_D: assert property (dir_d_write ##1 !host_wr_i |=>
		pin_oe_n_o[3] == {5'h1F, ~$past(host_wdata_i[2:0], 2)})
		else $error("narrow port direction wrong");
	AST_UNIMPL_D: assert property (host_rd_i && host_addr_i == 6'h33 |=>
		host_rdata_o[7:3] == 5'h00)
		else $error("unimplemented direction bits read nonzero");
	AST_UNMAPPED: assert property (host_rd_i && host_addr_i[3:0] > 4'h8 |=>
		host_rdata_o == 8'h00)
		else $error("unmapped read nonzero");
	AST_STATUS: assert property (host_rd_i && host_addr_i == 6'h08 |=>
		host_rdata_o == ~$past(pin_oe_n_o[0]))
		else $error("driver enable status mismatch");
	AST_LOGIC_OE: assert property (|logic_oe_i[1][3:0] |=>
		(pin_oe_n_o[1][3:0] & $past(logic_oe_i[1][3:0])) == 4'h0)
		else $error("logic enable did not drive pin");
	AST_SLEW_FIXED: assert property (slew_fast_o[2] == 8'h00 &&
		slew_fast_o[3][7:3] == 5'h00)
		else $error("slew set on pin without slew control");
	AST_OUT_READBACK: assert property (out_a_write ##2 out_a_read |=>
		host_rdata_o == $past(host_wdata_i, 3))
		else $error("output value readback wrong");
endmodule

bind port_config_data_regs port_regs_sva #(.W(W)) sva (.clk_i, .rstn_i, .host_addr_i,
	.host_wdata_i, .host_wr_i, .host_rd_i, .host_rdata_o, .pin_oe_n_o, .slew_fast_o,
	.logic_oe_i);
`default_nettype wire

/* sim/pin_partner.sv */
`default_nettype none
module pin_partner (
	input wire logic [3:0][7:0] drv_i,
	input wire logic [3:0][7:0] oe_n_i,
	input wire logic [3:0][7:0] ext_i,
	input wire logic [3:0][7:0] ext_en_i,
	output logic [3:0][7:0] level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// released pins sit on the board pull-up unless something outside drives them
	assign level_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_i) | (oe_n_i & ~ext_en_i);
endmodule
`default_nettype wire

/* sim/port_config_data_regs_bench.sv */
`default_nettype none
module port_config_data_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rstn_i = 1'b0, host_wr_i = 1'b0, host_rd_i = 1'b0;
	logic data_port_mode_i = 1'b0, peripheral_mode_i = 1'b0, bus_drive_i = 1'b0;
	logic group_first_to_second_i = 1'b0, group_second_to_third_i = 1'b0;
	logic group_first_load_i = 1'b0, group_second_load_i = 1'b0;
	logic [5:0] host_addr_i = 6'h00;
	logic [7:0] host_wdata_i = 8'h00, bus_data_i = 8'h00, host_rdata_o;
	logic [7:0] group_first_d_i = 8'h00, group_second_d_i = 8'h00;
	logic [7:0] output_cell_group_first_o, output_cell_group_second_o;
	logic [3:0][7:0] pin_i, pin_o, pin_oe_n_o, slew_fast_o;
	logic [3:0][7:0] ext = 32'h0, ext_en = 32'h0;
	logic [2:0][7:0] logic_oe_i = 24'h0, pin_uses_cell_i = 24'h0, input_cell_o;
	logic [1:0][7:0] latched_addr_i = 16'h0;
	logic [2:0] input_cell_strobe_i = 3'h0;
	int errors = 0;
	int compares = 0;

	port_config_data_regs DUT (.clk_i, .rstn_i, .host_addr_i, .host_wdata_i, .host_wr_i,
		.host_rd_i, .host_rdata_o, .pin_i, .pin_o, .pin_oe_n_o, .slew_fast_o, .logic_oe_i,
		.pin_uses_cell_i, .latched_addr_i, .group_first_to_second_i,
		.group_second_to_third_i, .group_first_d_i, .group_first_load_i, .group_second_d_i,
		.group_second_load_i, .output_cell_group_first_o, .output_cell_group_second_o,
		.input_cell_strobe_i, .input_cell_o, .data_port_mode_i, .peripheral_mode_i,
		.bus_drive_i, .bus_data_i);
	pin_partner pins (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .ext_i(ext), .ext_en_i(ext_en),
		.level_o(pin_i));

	initial
	begin
		forever
			#50 clk_i = ~clk_i;
	end

	task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string what);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// strobes drop for one idle edge so back-to-back calls never retoggle them in one step
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		host_addr_i = a;
		host_wdata_i = d;
		host_wr_i = 1'b1;
		@(negedge clk_i);
		host_wr_i = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
		host_addr_i = a;
		host_rd_i = 1'b1;
		@(negedge clk_i);
		host_rd_i = 1'b0;
		chk(exp, host_rdata_o, $sformatf("reg %h", a));
		@(negedge clk_i);
	endtask

	task automatic final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		#(3000 * 100);
		errors++;
		final_report();
	end

	initial
	begin
		repeat (8) @(negedge clk_i);
		rstn_i = 1'b1;
		for (int p = 0; p < 4; p++)
		begin
			chk(8'hFF, pin_oe_n_o[p], "oe_n reset");
			for (int r = 1; r < 7; r++)
				rd_reg({p[1:0], r[3:0]}, 8'h00);
		end
		wr_reg(6'h13, 8'h0F);
		@(negedge clk_i);
		chk(8'hF0, pin_oe_n_o[1], "oe_n B");
		rd_reg(6'h18, 8'h0F);
		rd_reg(6'h10, 8'hF0);
		wr_reg(6'h33, 8'hFF);
		rd_reg(6'h33, 8'h07);
		chk(8'hF8, pin_oe_n_o[3], "oe_n D");
		wr_reg(6'h34, 8'hFF);
		rd_reg(6'h34, 8'h07);
		chk(8'h07, slew_fast_o[3], "slew D");
		ext[0] = 8'h3C;
		ext_en[0] = 8'hFF;
		wr_reg(6'h02, 8'hA5);
		rd_reg(6'h02, 8'hA5);
		rd_reg(6'h00, 8'h3C);
		wr_reg(6'h03, 8'hFF);
		@(negedge clk_i);
		chk(8'hA5, pin_o[0], "pin A");
		rd_reg(6'h08, 8'hFF);
		wr_reg(6'h04, 8'hFF);
		@(negedge clk_i);
		chk(8'h0F, slew_fast_o[0], "slew A");
		chk(8'hA0, pin_oe_n_o[0], "open drain A");
		logic_oe_i = 24'h813100;
		@(negedge clk_i);
		chk(8'h7E, pin_oe_n_o[2], "oe_n C");
		chk(8'hC0, pin_oe_n_o[1], "oe_n B");
		// let the pad flops release port C before latching it
		logic_oe_i = 24'h0;
		ext[2] = 8'h5A;
		ext_en[2] = 8'hFF;
		@(negedge clk_i);
		input_cell_strobe_i = 3'h4;
		@(negedge clk_i);
		input_cell_strobe_i = 3'h0;
		rd_reg(6'h27, 8'h5A);
		chk(8'h5A, input_cell_o[2], "input cell C");
		wr_reg(6'h06, 8'h0F);
		wr_reg(6'h05, 8'hFF);
		rd_reg(6'h05, 8'hF0);
		chk(8'hF0, output_cell_group_first_o, "cell group");
		group_first_to_second_i = 1'b1;
		wr_reg(6'h15, 8'h3C);
		chk(8'h3C, output_cell_group_first_o, "cell group");
		group_second_to_third_i = 1'b1;
		pin_uses_cell_i[2] = 8'hFF;
		wr_reg(6'h25, 8'hC3);
		chk(8'hC3, output_cell_group_second_o, "cell group 2");
		wr_reg(6'h23, 8'hFF);
		chk(8'hC3, pin_o[2], "cell pin C");
		wr_reg(6'h26, 8'hF0);
		wr_reg(6'h25, 8'h00);
		rd_reg(6'h25, 8'hC0);
		rd_reg(6'h0F, 8'h00);
		latched_addr_i[1] = 8'h0A;
		wr_reg(6'h11, 8'h0F);
		@(negedge clk_i);
		chk(8'h0A, {4'h0, pin_o[1][3:0]}, "address out B");
		data_port_mode_i = 1'b1;
		bus_drive_i = 1'b1;
		bus_data_i = 8'h96;
		@(negedge clk_i);
		chk(8'h96, pin_o[0], "bus A");
		chk(8'h00, pin_oe_n_o[0], "bus oe_n A");
		data_port_mode_i = 1'b0;
		peripheral_mode_i = 1'b1;
		bus_drive_i = 1'b0;
		@(negedge clk_i);
		chk(8'hFF, pin_oe_n_o[0], "buffer off A");
		final_report();
	end
endmodule
`default_nettype wire
